/* rtl/jtag_port_params.svh */
// timing counts, pin indices, instruction codes and reset values
`ifndef JTAG_PORT_PARAMS_SVH
`define JTAG_PORT_PARAMS_SVH
// ==========================================
// clock and timing
`define CLK_PERIOD_NS    5.0
`define T_CRESET_MIN_US  0.32
`define T_USER_MIN_US    25.0
`define LOAD_CYCLES      64
`define CNT_W            16
// ==========================================
// synchroniser lanes and reset values
`define SYNC_W           5
`define PIN_TCK          0
`define PIN_TMS          1
`define PIN_TDI          2
`define PIN_CRESET       3
`define PIN_CONFIG_COMPLETE_FLAG        4
`define SYNC_RST         5'h1e
// ==========================================
// test logic registers
`define IR_W             4
`define DR_W             32
`define IR_CAPTURE       4'h1
`define IR_IDCODE        4'h3
`define IR_PROGRAM       4'h4
`define IR_ENTER_USER    4'h7
`define IR_BYPASS        4'hf
`endif

/* rtl/jtag_port_pkg.sv */
// types shared by the configuration status and test access port
`include "jtag_port_params.svh"
package jtag_port_pkg;
  // ==========================================
  // tap controller and configuration sequencer states
  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    CFG_LOAD = 3'h1,
    CFG_DONE = 3'h2,
    CFG_USER = 3'h4
  } cfg_state_t;

  // ==========================================
  // pad drive bundle
  typedef struct packed {
    logic cdoneOut;
    logic cdoneOe;
    logic tdoOut;
    logic tdoOe;
    logic tmsPullUp;
    logic tdiPullUp;
  } pad_out_t;

  // ==========================================
  // per-module state
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] filt;
  } sync_reg_t;

  typedef struct packed {
    tap_state_t tap;
  } tap_reg_t;

  typedef struct packed {
    cfg_state_t        cfg;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] lowCnt;
    logic              cresetPrev;
    logic              tckPrev;
    logic              jtagProg;
    logic              enterUserSeen;
    logic [`IR_W-1:0]  ir;
    logic [`IR_W-1:0]  irShift;
    logic [`DR_W-1:0]  drShift;
    logic [`DR_W-1:0]  progWord;
    logic              tdo;
    logic              tdoOe;
  } port_reg_t;
endpackage

/* rtl/pin_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module pin_sync (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // raw pins and filtered levels
  input  wire logic [`SYNC_W-1:0]  pinRaw,
  output      logic [`SYNC_W-1:0]  pinLevel
);
  import jtag_port_pkg::*;

  sync_reg_t         st_r;
  sync_reg_t         st_nxt;
  logic [`SYNC_W-1:0] agree;

  // ==========================================
  // a lane moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi++) begin : g_lane
      assign agree[gi] = (st_r.s2[gi] == st_r.s3[gi]);
    end
  endgenerate

  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pinRaw;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (st_r.s3 & agree) | (st_r.filt & ~agree);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{`SYNC_RST, `SYNC_RST, `SYNC_RST, `SYNC_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinLevel = st_r.filt;
endmodule

/* rtl/tap_fsm.sv */
// sixteen-state test access port controller
`timescale 1ns/100ps
module tap_fsm (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // stepping
  input  wire logic                      step,
  input  wire logic                      tms,
  output      jtag_port_pkg::tap_state_t state
);
  import jtag_port_pkg::*;

  tap_reg_t st_r;
  tap_reg_t st_nxt;

  // ==========================================
  // standard state walk
  always_comb begin
    st_nxt = st_r;
    if (step) begin
      case (st_r.tap)
        TAP_RESET:  st_nxt.tap = tms ? TAP_RESET  : TAP_IDLE;
        TAP_IDLE:   st_nxt.tap = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: st_nxt.tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: st_nxt.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR:  st_nxt.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: st_nxt.tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
        TAP_PAU_DR: st_nxt.tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
        TAP_EX2_DR: st_nxt.tap = tms ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: st_nxt.tap = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: st_nxt.tap = tms ? TAP_RESET  : TAP_CAP_IR;
        TAP_CAP_IR: st_nxt.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR:  st_nxt.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: st_nxt.tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
        TAP_PAU_IR: st_nxt.tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
        TAP_EX2_IR: st_nxt.tap = tms ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: st_nxt.tap = tms ? TAP_SEL_DR : TAP_IDLE;
        default:    st_nxt.tap = TAP_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{tap: TAP_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state = st_r.tap;

  // moves only on a test clock rise
  chk_tap_step: assert property (@(posedge clk) disable iff (!reset_n)
    !step |=> $stable(st_r.tap))
    else $error("tap state moved without a test clock rise");
endmodule

/* rtl/config_status_and_jtag_port.sv */
// configuration status pin, re-configuration request and test access port
//
// What this block does
// - completion pin is open drain: pull low or release, never drive high
// - completion pin released, reading 1, only once configuration completes
// - user mode entered only while completion pin reads high; outsiders may hold it low
// - re-configuration request restarts configuration only, never resets user logic
// - mode-select and serial input sampled on each test clock rise
// - serial output changes only after a test clock fall
// - mode-select has a weak pull-up, reads 1 when undriven
// - serial input has a weak pull-up, reads 1 when undriven
// - serial input shifts into instruction or selected data register
// - host changes serial input after falls; device shifts on rises
// - serial output comes from instruction or selected data register
// - shifted bit reaches output after register-length test clock cycles
// - serial output goes inactive when nothing is shifting
// - user-entry time after test programming starts at pin high plus enter-user
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module config_status_and_jtag_port #(
  parameter int               USER_MIN_CYC = int'($ceil(`T_USER_MIN_US * 1000.0 / `CLK_PERIOD_NS)),
  parameter int               LOAD_CYC     = `LOAD_CYCLES,
  // arbitrary identification value
  parameter logic [`DR_W-1:0] ID_VALUE     = 32'h0a5a_0001
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // configuration pins
  input  wire logic                    cresetReqN,
  input  wire logic                    cdoneIn,
  // test access pins
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  // pad drive
  output      jtag_port_pkg::pad_out_t padOut,
  // status
  output      logic                    userMode,
  output      logic                    configBusy
);
  import jtag_port_pkg::*;

  // ==========================================
  // timing counts
  localparam real               T_CRESET_MIN_US = `T_CRESET_MIN_US;
  localparam int                CRESET_MIN_CYC  = int'($ceil(T_CRESET_MIN_US * 1000.0 / `CLK_PERIOD_NS));
  localparam logic [`CNT_W-1:0] CRESET_MIN      = `CNT_W'(CRESET_MIN_CYC);
  localparam logic [`CNT_W-1:0] USER_LAST       = `CNT_W'(USER_MIN_CYC - 1);
  localparam logic [`CNT_W-1:0] LOAD_LAST       = `CNT_W'(LOAD_CYC - 1);
  localparam logic [`CNT_W-1:0] CNT_MAX         = {`CNT_W{1'b1}};

  port_reg_t          st_r;
  port_reg_t          st_nxt;
  logic [`SYNC_W-1:0] pinLevel;
  tap_state_t         tapState;
  logic               pinTck;
  logic               pinTms;
  logic               pinTdi;
  logic               pinCreset;
  logic               pinCdone;
  logic               tckRise;
  logic               tckFall;
  logic               cresetRise;
  logic               reconfig;
  logic               wideDr;
  logic               shifting;

  // ==========================================
  // pin synchronisers
  // all lanes share one latency, so tms and tdi line up with the tck edge seen
  pin_sync u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pinRaw   ({cdoneIn, cresetReqN, tdi, tms, tck}),
    .pinLevel (pinLevel)
  );

  assign pinTck    = pinLevel[`PIN_TCK];
  assign pinTms    = pinLevel[`PIN_TMS];
  assign pinTdi    = pinLevel[`PIN_TDI];
  assign pinCreset = pinLevel[`PIN_CRESET];
  assign pinCdone  = pinLevel[`PIN_CONFIG_COMPLETE_FLAG];

  assign tckRise    = pinTck & ~st_r.tckPrev;
  assign tckFall    = ~pinTck & st_r.tckPrev;
  assign cresetRise = pinCreset & ~st_r.cresetPrev;
  // pulses shorter than the minimum are ignored
  assign reconfig   = cresetRise & (st_r.lowCnt >= CRESET_MIN);

  // ==========================================
  // tap controller
  // the request pin never reaches the controller or its reset
  tap_fsm u_tap (
    .clk     (clk),
    .reset_n (reset_n),
    .step    (tckRise),
    .tms     (pinTms),
    .state   (tapState)
  );

  // only identification and program words are long; all else is bypass
  assign wideDr   = (st_r.ir == `IR_IDCODE) || (st_r.ir == `IR_PROGRAM);
  assign shifting = (tapState == TAP_SH_DR) || (tapState == TAP_SH_IR);

  // ==========================================
  // next state
  always_comb begin
    st_nxt            = st_r;
    st_nxt.tckPrev    = pinTck;
    st_nxt.cresetPrev = pinCreset;

    if (!pinCreset) begin
      st_nxt.lowCnt = (st_r.lowCnt == CNT_MAX) ? st_r.lowCnt : st_r.lowCnt + 1'b1;
    end else begin
      st_nxt.lowCnt = '0;
    end

    // registers shift on the rise, decided by the state being left
    if (tckRise) begin
      case (tapState)
        TAP_RESET: begin
          st_nxt.ir = `IR_IDCODE;
        end
        TAP_CAP_IR: begin
          st_nxt.irShift = `IR_CAPTURE;
        end
        TAP_SH_IR: begin
          st_nxt.irShift = {pinTdi, st_r.irShift[`IR_W-1:1]};
        end
        TAP_UPD_IR: begin
          st_nxt.ir = st_r.irShift;
          if (st_r.irShift == `IR_PROGRAM) begin
            st_nxt.jtagProg      = 1'b1;
            st_nxt.enterUserSeen = 1'b0;
          end
          // enter-user taken in the update state
          if (st_r.irShift == `IR_ENTER_USER) begin
            st_nxt.enterUserSeen = 1'b1;
          end
        end
        TAP_CAP_DR: begin
          case (st_r.ir)
            `IR_IDCODE:  st_nxt.drShift = ID_VALUE;
            `IR_PROGRAM: st_nxt.drShift = st_r.progWord;
            default:     st_nxt.drShift = '0;
          endcase
        end
        // data path, length follows the selected register
        TAP_SH_DR: begin
          if (wideDr) begin
            st_nxt.drShift = {pinTdi, st_r.drShift[`DR_W-1:1]};
          end else begin
            st_nxt.drShift[0] = pinTdi;
          end
        end
        TAP_UPD_DR: begin
          if (st_r.ir == `IR_PROGRAM) begin
            st_nxt.progWord = st_r.drShift;
          end
        end
        default: begin
          st_nxt.ir = st_r.ir;
        end
      endcase
    end

    // output updated only on the fall, from the path in use
    if (tckFall) begin
      // drive only while a shift state is current
      st_nxt.tdoOe = shifting;
      if (tapState == TAP_SH_IR) begin
        st_nxt.tdo = st_r.irShift[0];
      end else if (tapState == TAP_SH_DR) begin
        st_nxt.tdo = st_r.drShift[0];
      end
    end

    // configuration sequencer
    case (st_r.cfg)
      CFG_LOAD: begin
        // a test-loaded image completes on its first program word update
        if (st_r.jtagProg) begin
          if (tckRise && (tapState == TAP_UPD_DR) && (st_r.ir == `IR_PROGRAM)) begin
            st_nxt.cfg = CFG_DONE;
            st_nxt.cnt = '0;
          end
        end else if (st_r.cnt >= LOAD_LAST) begin
          st_nxt.cfg = CFG_DONE;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      CFG_DONE: begin
        // count only while the pin reads high and, after test loading, enter-user was seen
        if (pinCdone && (!st_r.jtagProg || st_r.enterUserSeen)) begin
          if (st_r.cnt >= USER_LAST) begin
            st_nxt.cfg = CFG_USER;
          end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
          end
        end else begin
          st_nxt.cnt = '0;
        end
      end
      CFG_USER: begin
        st_nxt.cnt = '0;
      end
      default: begin
        st_nxt.cfg = CFG_LOAD;
        st_nxt.cnt = '0;
      end
    endcase

    // test-program restart overrides the sequencer case; the request-pin restart below is applied after it
    if (tckRise && (tapState == TAP_UPD_IR) && (st_r.irShift == `IR_PROGRAM)) begin
      st_nxt.cfg = CFG_LOAD;
      st_nxt.cnt = '0;
    end
    // rising edge after a long enough low restarts loading
    if (reconfig) begin
      st_nxt.cfg           = CFG_LOAD;
      st_nxt.cnt           = '0;
      st_nxt.jtagProg      = 1'b0;
      st_nxt.enterUserSeen = 1'b0;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{cfg: CFG_LOAD, cnt: '0, lowCnt: '0, cresetPrev: 1'b1, tckPrev: 1'b0,
                jtagProg: 1'b0, enterUserSeen: 1'b0, ir: `IR_IDCODE, irShift: '0,
                drShift: '0, progWord: '0, tdo: 1'b0, tdoOe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  // low or released, never high
  assign padOut.cdoneOut  = 1'b0;
  assign padOut.cdoneOe   = (st_r.cfg == CFG_LOAD);
  assign padOut.tdoOut    = st_r.tdo;
  assign padOut.tdoOe     = st_r.tdoOe;
  assign padOut.tmsPullUp = 1'b1;
  // weak pull-up request on serial input
  assign padOut.tdiPullUp = 1'b1;
  assign userMode         = (st_r.cfg == CFG_USER);
  assign configBusy       = (st_r.cfg == CFG_LOAD);

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_config_complete_flag_opendrain: assert property (padOut.cdoneOe |-> !padOut.cdoneOut)
    else $error("completion pin driven high");

  chk_config_complete_flag_released: assert property (userMode |-> !padOut.cdoneOe)
    else $error("completion pin pulled low in user mode");

  chk_user_gate: assert property ($rose(userMode) |-> $past(pinCdone) && $past(st_r.cnt) == USER_LAST)
    else $error("user mode entered without the pin high for the full time");

  chk_reconfig_start: assert property (reconfig |=> configBusy ##1 padOut.cdoneOe)
    else $error("valid re-configuration request not honoured");

  chk_short_pulse: assert property (cresetRise && !reconfig && !tckRise && userMode |=> userMode)
    else $error("short re-configuration pulse acted");

  chk_tdo_on_fall: assert property (!tckFall |=> $stable(padOut.tdoOut) && $stable(padOut.tdoOe))
    else $error("serial output moved away from a test clock fall");

  chk_tdo_idle: assert property (tckFall && !shifting |=> !padOut.tdoOe)
    else $error("serial output driven outside shifting");

  chk_ir_shift: assert property (tckRise && tapState == TAP_SH_IR |=> st_r.irShift[`IR_W-1] == $past(pinTdi))
    else $error("instruction path did not take the serial input");

  chk_bypass_len: assert property (tckRise && tapState == TAP_SH_DR && !wideDr |=> st_r.drShift[0] == $past(pinTdi))
    else $error("bypass path is not one stage long");

  chk_enter_user: assert property ($rose(userMode) |-> !st_r.jtagProg || st_r.enterUserSeen)
    else $error("test-loaded image entered user mode without enter-user");

  chk_ir_update: assert property (tckRise && tapState == TAP_UPD_IR |=> st_r.ir == $past(st_r.irShift))
    else $error("instruction not updated");
endmodule

/* testbench/jtag_host_model.sv */
// behavioural test host for the test access pins, with pulled-up lines
`timescale 1ns/100ps
module jtag_host_model (
  // test access pins
  output logic                         tck,
  output wire logic                    tms,
  output wire logic                    tdi,
  // device pad drive
  input  wire jtag_port_pkg::pad_out_t padOut
);
  import jtag_port_pkg::*;
  logic tmsVal;
  logic tdiVal;
  logic tmsDrive;
  logic tdiDrive;
  logic tdoLine;
  int   tdoBad;
  // ==========================================
  // pin levels
  // undriven mode-select reads the pull-up, else the inverse of the last value
  assign tms = tmsDrive ? tmsVal : (padOut.tmsPullUp ? 1'b1 : ~tmsVal);
  // undriven serial input reads the pull-up, else the inverse of the last value
  assign tdi = tdiDrive ? tdiVal : (padOut.tdiPullUp ? 1'b1 : ~tdiVal);
  // released output never shows the last bit, so a missing enable cannot hide
  assign tdoLine = padOut.tdoOe ? padOut.tdoOut : ~padOut.tdoOut;
  initial begin
    tck = 1'b0;
    tmsVal = 1'b1;
    tdiVal = 1'b1;
    tmsDrive = 1'b1;
    tdiDrive = 1'b1;
    tdoBad = 0;
  end
  // ==========================================
  // watch and drive
  // output must not move while the test clock is high
  always @(padOut.tdoOut or padOut.tdoOe) begin
    if (tck === 1'b1) begin
      tdoBad++;
    end
  end
  // inputs change only after a fall; clock stands low between frames
  task automatic walk(input int n, input logic [31:0] m, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      tmsVal = m[i];
      tdiVal = d[i];
      #32 tck = 1'b1;
      q[i] = tdoLine;
      #32 tck = 1'b0;
    end
  endtask
endmodule

/* testbench/config_status_and_jtag_port_tb.sv */
// self-checking bench for the configuration status and test access port
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module config_status_and_jtag_port_tb;
  import jtag_port_pkg::*;
  localparam int          USER_SIM = 20;
  localparam int          LOAD_SIM = 8;
  // arbitrary identification value
  localparam logic [31:0] ID_VAL   = 32'h0a5a_0001;
  logic     clk;
  logic     reset_n;
  logic     cresetReqN;
  logic     extHold;
  wire      cdoneIn;
  wire      tck;
  wire      tms;
  wire      tdi;
  pad_out_t padOut;
  logic     userMode;
  logic     configBusy;
  int       errors;
  int       cmpCount;
  // open-drain completion pin: pulled up unless either party pulls low
  assign cdoneIn = padOut.cdoneOe ? 1'b0 : ~extHold;
  config_status_and_jtag_port #(
    .USER_MIN_CYC (USER_SIM),
    .LOAD_CYC     (LOAD_SIM),
    .ID_VALUE     (ID_VAL)
  ) config_status_and_jtag_port_i (
    .clk        (clk),
    .reset_n    (reset_n),
    .cresetReqN (cresetReqN),
    .cdoneIn    (cdoneIn),
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .padOut     (padOut),
    .userMode   (userMode),
    .configBusy (configBusy)
  );
  jtag_host_model jtag_host_model_i (
    .tck    (tck),
    .tms    (tms),
    .tdi    (tdi),
    .padOut (padOut)
  );
  always #2.5 clk = ~clk;
  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pinDrive(input logic crst, input logic hold);
    @(posedge clk);
    cresetReqN <= crst;
    extHold <= hold;
  endtask
  task automatic waitUser(output int n);
    for (n = 0; n < 60 && userMode !== 1'b1; n++) @(negedge clk);
  endtask
  task automatic tapReset();
    logic [31:0] q;
    jtag_host_model_i.walk(6, 32'h1f, 32'h0, q);
  endtask
  task automatic irLoad(input logic [3:0] code, output logic [3:0] cap);
    logic [31:0] q;
    jtag_host_model_i.walk(10, 32'h183, {24'h0, code, 4'h0}, q);
    cap = q[7:4];
  endtask
  task automatic drShift(input int n, input logic [31:0] d, output logic [31:0] q);
    logic [31:0] x;
    jtag_host_model_i.walk(3, 32'h1, 32'h0, x);
    jtag_host_model_i.walk(n, 32'h1 << (n - 1), d, q);
    jtag_host_model_i.walk(2, 32'h1, 32'h0, x);
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_up();
    int n;
    tick(16);
    check({padOut.cdoneOut, padOut.cdoneOe, userMode}, 3'b010);
    check({padOut.tdoOe, padOut.tmsPullUp, padOut.tdiPullUp}, 3'b011);
    @(posedge clk);
    reset_n <= 1'b1;
    for (n = 0; n < 40 && configBusy !== 1'b0; n++) @(negedge clk);
    check(n >= LOAD_SIM - 1 && n <= LOAD_SIM + 2, 1);
    check(userMode, 0);
    // bench keeps clear of the user side until user mode, past the minimum
    waitUser(n);
    check(n >= USER_SIM && n <= USER_SIM + 12, 1);
  endtask
  task automatic t_ir_capture();
    logic [3:0] c;
    tapReset();
    irLoad(`IR_BYPASS, c);
    check(c, `IR_CAPTURE);
    tick(8);
    check(padOut.tdoOe, 0);
  endtask
  task automatic t_bypass();
    logic [31:0] q;
    drShift(8, 32'hb4, q);
    check(q[7:0], 8'h68);
    // through pause and back into shifting: released line in between, shifted bit after
    jtag_host_model_i.walk(3, 32'h1, 32'h0, q);
    jtag_host_model_i.walk(7, 32'h35, 32'h0, q);
    check(q[4:0], 5'h0e);
  endtask
  task automatic t_idcode();
    logic [31:0] q;
    tapReset();
    drShift(32, 32'h0, q);
    check(q, ID_VAL);
  endtask
  task automatic t_pull_ups();
    logic [3:0]  c;
    logic [31:0] q;
    irLoad(`IR_BYPASS, c);
    check(c, `IR_CAPTURE);
    jtag_host_model_i.tdiDrive = 1'b0;
    drShift(4, 32'hf, q);
    check(q[3:0], 4'he);
    jtag_host_model_i.tdiDrive = 1'b1;
    jtag_host_model_i.tmsDrive = 1'b0;
    jtag_host_model_i.walk(5, 32'h1f, 32'h0, q);
    jtag_host_model_i.tmsDrive = 1'b1;
    jtag_host_model_i.walk(1, 32'h0, 32'h0, q);
    drShift(32, 32'h0, q);
    check(q, ID_VAL);
  endtask
  task automatic t_hold_reconfig();
    logic [3:0]  c;
    logic [31:0] q;
    int          n;
    irLoad(`IR_BYPASS, c);
    // low pulse of 70 cycles, just over the minimum
    pinDrive(1'b0, 1'b1);
    tick(70);
    pinDrive(1'b1, 1'b1);
    tick(10);
    check({configBusy, userMode}, 2'b10);
    tick(200);
    check({configBusy, userMode}, 2'b00);
    pinDrive(1'b1, 1'b0);
    waitUser(n);
    check(userMode, 1);
    drShift(4, 32'hf, q);
    check(q[3:0], 4'he);
  endtask
  task automatic t_short_pulse();
    int hits;
    hits = 0;
    pinDrive(1'b0, 1'b0);
    tick(30);
    pinDrive(1'b1, 1'b0);
    repeat (30) begin
      @(negedge clk);
      hits += int'(configBusy !== 1'b0);
    end
    check(hits, 0);
    check(userMode, 1);
  endtask
  task automatic t_jtag_program();
    logic [3:0]  c;
    logic [31:0] q;
    int          n;
    irLoad(`IR_PROGRAM, c);
    tick(8);
    check({configBusy, userMode}, 2'b10);
    drShift(32, 32'h1234_5678, q);
    tick(8);
    check(configBusy, 0);
    tick(60);
    check(userMode, 0);
    irLoad(`IR_ENTER_USER, c);
    check(userMode, 0);
    waitUser(n);
    check(userMode, 1);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    cresetReqN = 1'b1;
    extHold = 1'b0;
    errors = 0;
    cmpCount = 0;
    t_power_up();
    t_ir_capture();
    t_bypass();
    t_idcode();
    t_pull_ups();
    t_hold_reconfig();
    t_short_pulse();
    t_jtag_program();
    check(jtag_host_model_i.tdoBad, 0);
    check(padOut.cdoneOut, 0);
    final_report();
  end
  // the whole run needs about 17 us; well past that something hangs
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule
